// [rtl/tpdg_ctrl.sv]
// Controller that drives the command pins of a three-phase gate driver.
// Assumes a 20 MHz clock, an APB master for the registers, and a driver
// whose dead-time programming pin is grounded by an external switch.
//
// How it works
// - Joined mode ties both commands together.
// - Separate mode adds own gap without overlap.
// - Joined mode needs internal dead time on.
// - Ground programming pin when dead time off.
`timescale 1ns/10ps
`default_nettype none
`include "tpdg_consts.svh"

module tpdg_ctrl
    import tpdg_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    resetn,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Driver command pins
    output logic      [`TPDG_PHASES-1:0] phase_low_cmd,
    output logic      [`TPDG_PHASES-1:0] phase_high_cmd_n,
    output logic                         drive_inhibit,
    output logic                         dead_time_short,
    // Driver status pin
    input  wire logic                    undervoltage_flag
);

    // ****************************************************************
    // State
    // ****************************************************************
    tpdg_state_t s_q;                          // Registered state
    tpdg_state_t s_d;                          // Next state
    logic [`TPDG_PHASES-1:0] raw;              // Wanted side, 1 is high side
    logic                    fault;            // Joined mode without dead time
    logic                    acc;              // APB access phase
    logic                    commit;           // Access completes this edge

    // Decode one register address to a read value
    function automatic logic [32:0] tpdg_read(input tpdg_state_t s,
                                              input logic [11:0] a,
                                              input logic f);
        logic [32:0] r;
        r = 33'h000000000;
        if (a == `TPDG_ADDR_CTRL) begin
            r[`TPDG_CTRL_RUN]     = s.run;
            r[`TPDG_CTRL_JOINED]  = s.joined;
            r[`TPDG_CTRL_DT_INT]  = s.dt_int;
            r[`TPDG_CTRL_INHIBIT] = s.inhibit;
        end else if (a == `TPDG_ADDR_PERIOD) begin
            r[`TPDG_CW-1:0] = s.period;
        end else if (a == `TPDG_ADDR_DEAD) begin
            r[`TPDG_CW-1:0] = s.dead;
        end else if (a == `TPDG_ADDR_DUTY_A) begin
            r[`TPDG_CW-1:0] = s.duty[0];
        end else if (a == `TPDG_ADDR_DUTY_B) begin
            r[`TPDG_CW-1:0] = s.duty[1];
        end else if (a == `TPDG_ADDR_DUTY_C) begin
            r[`TPDG_CW-1:0] = s.duty[2];
        end else if (a == `TPDG_ADDR_STATUS) begin
            r[`TPDG_STAT_UV]    = s.uv_sync[1];
            r[`TPDG_STAT_FAULT] = f;
            r[`TPDG_STAT_RAW_LO+`TPDG_PHASES-1:`TPDG_STAT_RAW_LO] = s.applied;
        end else begin
            r[32] = 1'b1;                      // Unmapped: error flag
        end
        return r;
    endfunction : tpdg_read

    // ****************************************************************
    // PWM compare per phase
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < `TPDG_PHASES; g++) begin : g_cmp
            // High side wanted while the count is below the duty; a duty
            // above the period holds the high side on with no timeout
            assign raw[g] = (s_q.cnt < s_q.duty[g]);
        end
    endgenerate

    assign fault  = s_q.joined & ~s_q.dt_int;
    assign acc    = psel & penable;
    assign commit = acc & s_q.pready;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [32:0] rd;
        rd  = 33'h000000000;
        s_d = s_q;
        // Undervoltage pin through two flops
        s_d.uv_sync = {s_q.uv_sync[0], undervoltage_flag};

        // APB: one wait state, then a registered answer
        s_d.pready  = acc & ~s_q.pready;
        s_d.prdata  = 32'h00000000;
        s_d.pslverr = 1'b0;
        if (acc & ~s_q.pready) begin
            rd          = tpdg_read(s_q, paddr, fault);
            s_d.prdata  = pwrite ? 32'h00000000 : rd[31:0];
            s_d.pslverr = rd[32];
        end
        if (commit & pwrite) begin
            if (paddr == `TPDG_ADDR_CTRL) begin
                s_d.run     = pwdata[`TPDG_CTRL_RUN];
                s_d.joined  = pwdata[`TPDG_CTRL_JOINED];
                s_d.dt_int  = pwdata[`TPDG_CTRL_DT_INT];
                s_d.inhibit = pwdata[`TPDG_CTRL_INHIBIT];
            end else if (paddr == `TPDG_ADDR_PERIOD) begin
                s_d.period = pwdata[`TPDG_CW-1:0];
            end else if (paddr == `TPDG_ADDR_DEAD) begin
                s_d.dead = pwdata[`TPDG_CW-1:0];
            end else if (paddr == `TPDG_ADDR_DUTY_A) begin
                s_d.duty[0] = pwdata[`TPDG_CW-1:0];
            end else if (paddr == `TPDG_ADDR_DUTY_B) begin
                s_d.duty[1] = pwdata[`TPDG_CW-1:0];
            end else if (paddr == `TPDG_ADDR_DUTY_C) begin
                s_d.duty[2] = pwdata[`TPDG_CW-1:0];
            end
        end

        // Period counter
        if (!s_q.run || s_q.cnt >= s_q.period) begin
            s_d.cnt = `TPDG_CNT_ZERO;
        end else begin
            s_d.cnt = s_q.cnt + `TPDG_CNT_ONE;
        end

        // Grounding switch on the programming pin while dead time is off
        s_d.dt_short = ~s_q.dt_int;
        // Driver held off when stopped, inhibited or misconfigured
        s_d.drv_inh  = ~s_q.run | s_q.inhibit | fault;

        // Per-phase command pins
        for (int i = 0; i < `TPDG_PHASES; i++) begin
            if (!s_q.run || fault) begin
                // Both sides off, timers cleared
                s_d.low_cmd[i]    = 1'b0;
                s_d.high_cmd_n[i] = 1'b1;
                s_d.applied[i]    = 1'b0;
                s_d.gap[i]        = `TPDG_CNT_ZERO;
            end else if (s_q.joined) begin
                // One level per phase on both pins
                s_d.low_cmd[i]    = ~raw[i];
                s_d.high_cmd_n[i] = ~raw[i];
                s_d.applied[i]    = raw[i];
                s_d.gap[i]        = `TPDG_CNT_ZERO;
            end else if (s_q.gap[i] != `TPDG_CNT_ZERO) begin
                // Inside own dead time: both off, apply at the end
                s_d.gap[i] = s_q.gap[i] - `TPDG_CNT_ONE;
                if (s_q.gap[i] == `TPDG_CNT_ONE) begin
                    s_d.applied[i]    = raw[i];
                    s_d.low_cmd[i]    = ~raw[i];
                    s_d.high_cmd_n[i] = ~raw[i];
                end
            end else if (raw[i] != s_q.applied[i] ||
                         s_q.low_cmd[i] != s_q.high_cmd_n[i]) begin
                // Side change, or both off after a stop: break, make after the gap
                if (s_q.dead == `TPDG_CNT_ZERO) begin
                    s_d.applied[i]    = raw[i];
                    s_d.low_cmd[i]    = ~raw[i];
                    s_d.high_cmd_n[i] = ~raw[i];
                end else begin
                    s_d.low_cmd[i]    = 1'b0;
                    s_d.high_cmd_n[i] = 1'b1;
                    s_d.gap[i]        = s_q.dead;
                end
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_q            <= '0;
            s_q.period     <= `TPDG_PERIOD_RST;
            s_q.dead       <= `TPDG_DEAD_RST;
            s_q.duty       <= {`TPDG_PHASES{`TPDG_DUTY_RST}};
            s_q.high_cmd_n <= {`TPDG_PHASES{1'b1}};
            s_q.drv_inh    <= 1'b1;
            s_q.dt_short   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign prdata           = s_q.prdata;
    assign pready           = s_q.pready;
    assign pslverr          = s_q.pslverr;
    assign phase_low_cmd    = s_q.low_cmd;
    assign phase_high_cmd_n = s_q.high_cmd_n;
    assign drive_inhibit    = s_q.drv_inh;
    assign dead_time_short  = s_q.dt_short;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Second cycle running joined mode without fault: pins equal
    property p_joined_tied;
        s_q.run && s_q.joined && !fault ##1 s_q.run && s_q.joined && !fault
            |-> phase_low_cmd == phase_high_cmd_n;
    endproperty
    a_joined_tied: assert property (p_joined_tied)
        else $error("joined pins differ");

    // Never both sides commanded on in separate mode
    property p_no_overlap;
        !s_q.joined |-> (phase_low_cmd & ~phase_high_cmd_n) == 3'h0;
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("both sides commanded on");

    // Phase A low side turning off with a gap keeps high side off that cycle and the next, unless the gap has ended
    sequence s_low_off;
        !s_q.joined && s_q.run && s_q.dead != `TPDG_CNT_ZERO && $fell(phase_low_cmd[0]);
    endsequence
    property p_gap_after_low;
        s_low_off |-> phase_high_cmd_n[0] ##1
            (phase_high_cmd_n[0] || s_q.gap[0] == `TPDG_CNT_ZERO);
    endproperty
    a_gap_after_low: assert property (p_gap_after_low)
        else $error("high side on without gap");

    // Joined mode without internal dead time keeps the driver inhibited
    property p_joined_needs_dt;
        s_q.joined && !s_q.dt_int |=> drive_inhibit;
    endproperty
    a_joined_needs_dt: assert property (p_joined_needs_dt)
        else $error("joined mode not inhibited");

    // Grounding switch takes the inverse of dead-time enable one cycle later
    property p_dt_ground;
        $changed(s_q.dt_int) |=> dead_time_short == !$past(s_q.dt_int, 1) ##0
            $changed(dead_time_short);
    endproperty
    a_dt_ground: assert property (p_dt_ground)
        else $error("grounding switch wrong");

endmodule : tpdg_ctrl

`default_nettype wire

// [rtl/tpdg_consts.svh]
// Constants of the three-phase gate command controller.
// Assumes it is included by the package and the controller module.
`ifndef TPDG_CONSTS_SVH
`define TPDG_CONSTS_SVH

// Register byte addresses on the APB side
`define TPDG_ADDR_CTRL    12'h000
`define TPDG_ADDR_PERIOD  12'h004
`define TPDG_ADDR_DEAD    12'h008
`define TPDG_ADDR_DUTY_A  12'h00C
`define TPDG_ADDR_DUTY_B  12'h010
`define TPDG_ADDR_DUTY_C  12'h014
`define TPDG_ADDR_STATUS  12'h018

// Control register bit positions
`define TPDG_CTRL_RUN     0
`define TPDG_CTRL_JOINED  1
`define TPDG_CTRL_DT_INT  2
`define TPDG_CTRL_INHIBIT 3

// Status register bit positions
`define TPDG_STAT_UV      0
`define TPDG_STAT_FAULT   1
`define TPDG_STAT_RAW_LO  16

// Widths and reset values
`define TPDG_PHASES       3
`define TPDG_CW           16
`define TPDG_PERIOD_RST   16'h03E7
`define TPDG_DEAD_RST     16'h000A
`define TPDG_DUTY_RST     16'h0000
`define TPDG_CNT_ONE      16'h0001
`define TPDG_CNT_ZERO     16'h0000

`endif

// [rtl/tpdg_pkg.sv]
// Types of the three-phase gate command controller.
// Assumes tpdg_consts.svh is on the include path.
`include "tpdg_consts.svh"

package tpdg_pkg;

    // All state of the controller in one word
    typedef struct packed {
        logic                                  run;        // PWM running
        logic                                  joined;     // Joined input mode
        logic                                  dt_int;     // Internal dead time on
        logic                                  inhibit;    // Software inhibit
        logic [`TPDG_CW-1:0]                   period;     // Last count of a period
        logic [`TPDG_CW-1:0]                   dead;       // Own dead time in cycles
        logic [`TPDG_PHASES-1:0][`TPDG_CW-1:0] duty;       // High-side on counts
        logic [`TPDG_CW-1:0]                   cnt;        // Period counter
        logic [`TPDG_PHASES-1:0]               applied;    // Side now commanded
        logic [`TPDG_PHASES-1:0][`TPDG_CW-1:0] gap;        // Dead time remaining
        logic [`TPDG_PHASES-1:0]               low_cmd;    // Low-side command pins
        logic [`TPDG_PHASES-1:0]               high_cmd_n; // High-side command pins
        logic                                  drv_inh;    // Drive inhibit pin
        logic                                  dt_short;   // Dead time grounding
        logic [1:0]                            uv_sync;    // Undervoltage sync
        logic                                  pready;     // APB ready
        logic [31:0]                           prdata;     // APB read data
        logic                                  pslverr;    // APB error
    } tpdg_state_t;

endpackage : tpdg_pkg

// [verif/tpdg_drv_model.sv]
// Behavioural three-phase gate driver facing the controller's pins.
// Assumes the controller's clock; delay and refresh count in cycles.
`timescale 1ns/10ps
`default_nettype none

module tpdg_drv_model #(
    parameter int DT = 3, // Turn-on delay
    parameter int RF = 6  // Refresh length
) (
    // Clock and supply
    input  wire logic       clk,
    input  wire logic       supply_low,
    // Command pins
    input  wire logic [2:0] phase_low_cmd,
    input  wire logic [2:0] phase_high_cmd_n,
    input  wire logic       drive_inhibit,
    input  wire logic       dead_time_short,
    // Status and gates
    output logic            undervoltage_flag,
    output logic      [2:0] phase_low_gate,
    output logic      [2:0] phase_high_gate
);
    // ****************
    // Gate logic
    // ****************
    int         ton_l [3] = '{0, 0, 0}; // Low-side on time
    int         ton_h [3] = '{0, 0, 0}; // High-side on time
    int         rf_cnt    = 0;          // Refresh left
    logic       inh_q     = 1'h1;       // Inhibit seen last
    logic       uv_q      = 1'h1;       // Undervoltage seen last
    logic [2:0] wl;                     // Low sides wanted
    logic [2:0] wh;                     // High sides wanted
    assign undervoltage_flag = supply_low;
    assign wl = phase_low_cmd;
    // Low command wins unless the delay is grounded
    assign wh = ~phase_high_cmd_n & (dead_time_short ? 3'h7 : ~phase_low_cmd);
    // Refresh start and turn-on timers
    always @(posedge clk) begin
        inh_q <= drive_inhibit;
        uv_q <= supply_low;
        if ((inh_q && !drive_inhibit) || (uv_q && !supply_low)) begin
            rf_cnt <= RF;
        end else if (rf_cnt > 0) begin
            rf_cnt <= rf_cnt - 1;
        end
        for (int i = 0; i < 3; i++) begin
            // Timers restart so the first turn-on after refresh waits too
            ton_l[i] <= (wl[i] && rf_cnt == 0) ? ton_l[i] + 1 : 0;
            ton_h[i] <= (wh[i] && rf_cnt == 0) ? ton_h[i] + 1 : 0;
        end
    end
    // Delay on turn-on only, then refresh, then override
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            phase_low_gate[i] = wl[i] && (dead_time_short || ton_l[i] >= DT);
            phase_high_gate[i] = wh[i] && (dead_time_short || ton_h[i] >= DT);
        end
        if (rf_cnt > 0) begin
            phase_low_gate = 3'h7;
            phase_high_gate = 3'h0;
        end
        if (drive_inhibit || supply_low) begin
            phase_low_gate = 3'h0;
            phase_high_gate = 3'h0;
        end
    end
endmodule : tpdg_drv_model

`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench of the gate command controller.
// Assumes the controller and the driver model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "tpdg_consts.svh"

module testbench;
    // ****************
    // Harness
    // ****************
    localparam int DT = 3;
    localparam int RF = 6;
    logic        clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic        supply_low = 1'h0, pready, pslverr, erv, drive_inhibit, dead_time_short;
    logic        undervoltage_flag;
    logic [2:0]  phase_low_cmd, phase_high_cmd_n, phase_low_gate, phase_high_gate;
    int          miscompares = 0, checks = 0;
    initial begin
        forever #25 clk = ~clk;
    end
    tpdg_ctrl uut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .phase_low_cmd, .phase_high_cmd_n, .drive_inhibit,
        .dead_time_short, .undervoltage_flag);
    tpdg_drv_model #(.DT(DT), .RF(RF)) drv (.clk, .supply_low, .phase_low_cmd,
        .phase_high_cmd_n, .drive_inhibit, .dead_time_short, .undervoltage_flag,
        .phase_low_gate, .phase_high_gate);
    // ****************
    // Shared tasks
    // ****************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("checks %0d, miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic bound(input int n);
        if (n >= 50) begin
            miscompares++;
            $display("Error at %0t: wait ran out", $time);
            conclude();
        end
    endtask : bound
    // One APB transfer, released after the edge that sees pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        for (n = 0; n < 50 && pready !== 1'h1; n++) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        bound(n);
    endtask : apb
    task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d, rdv, erv);
    endtask : reg_write
    function automatic logic [31:0] pins();
        return 32'({phase_low_cmd, phase_high_cmd_n, drive_inhibit, dead_time_short});
    endfunction : pins
    // Commands never overlap on a phase
    always @(posedge clk) begin
        if (resetn) begin
            check(32'(phase_low_cmd & ~phase_high_cmd_n), 32'h0);
        end
    end
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset;
        logic [11:0] at [6] = '{`TPDG_ADDR_CTRL, `TPDG_ADDR_PERIOD, `TPDG_ADDR_DEAD,
                                `TPDG_ADDR_DUTY_A, `TPDG_ADDR_DUTY_B, `TPDG_ADDR_DUTY_C};
        logic [31:0] et [6] = '{32'h0, 32'h3E7, 32'hA, 32'h0, 32'h0, 32'h0};
        check(pins(), 32'h1F);
        for (int i = 0; i < 6; i++) begin
            apb(1'h0, at[i], 32'h0, rdv, erv);
            check(rdv, et[i]);
        end
        apb(1'h0, 12'h01C, 32'h0, rdv, erv);
        check({rdv[30:0], erv}, 32'h1);
    endtask : t_reset
    task automatic t_separate;
        int n;
        reg_write(`TPDG_ADDR_PERIOD, 32'h9);
        reg_write(`TPDG_ADDR_DEAD, 32'h2);
        reg_write(`TPDG_ADDR_DUTY_A, 32'h5);
        reg_write(`TPDG_ADDR_DUTY_B, 32'hFFFF);
        reg_write(`TPDG_ADDR_CTRL, 32'h5);
        for (n = 0; n < 50 && phase_high_cmd_n[0] !== 1'h0; n++) begin
            @(posedge clk);
        end
        bound(n);
        for (n = 0; n < 50 && phase_high_cmd_n[0] !== 1'h1; n++) begin
            @(posedge clk);
        end
        bound(n);
        for (n = 0; n < 50 && phase_low_cmd[0] !== 1'h1; n++) begin
            @(posedge clk);
        end
        check(32'(n), 32'h2);
        repeat (12) @(posedge clk);
        check(32'({phase_low_cmd[2:1], phase_high_cmd_n[2:1]}), 32'hA);
        check(32'({drive_inhibit, dead_time_short}), 32'h0);
        for (n = 0; n < 30; n++) begin
            @(posedge clk);
            check(32'({phase_high_cmd_n[1], phase_high_gate[1]}), 32'h1);
        end
    endtask : t_separate
    task automatic t_joined;
        reg_write(`TPDG_ADDR_CTRL, 32'h7);
        repeat (4) @(posedge clk);
        for (int n = 0; n < 20; n++) begin
            @(posedge clk);
            check(32'(phase_low_cmd ^ phase_high_cmd_n), 32'h0);
        end
        reg_write(`TPDG_ADDR_CTRL, 32'h3);
        repeat (3) @(posedge clk);
        check(pins(), 32'h1F);
        apb(1'h0, `TPDG_ADDR_STATUS, 32'h0, rdv, erv);
        check(rdv & 32'h2, 32'h2);
    endtask : t_joined
    task automatic t_refresh;
        reg_write(`TPDG_ADDR_CTRL, 32'h5);
        repeat (4) @(posedge clk);
        check(32'({phase_low_gate, phase_high_gate}), 32'h38);
        reg_write(`TPDG_ADDR_CTRL, 32'hD);
        repeat (2) @(posedge clk);
        check(32'({drive_inhibit, phase_low_gate, phase_high_gate}), 32'h40);
        reg_write(`TPDG_ADDR_CTRL, 32'h5);
        supply_low <= 1'h1;
        repeat (4) @(posedge clk);
        check(32'({phase_low_gate, phase_high_gate}), 32'h0);
        apb(1'h0, `TPDG_ADDR_STATUS, 32'h0, rdv, erv);
        check(rdv & 32'h1, 32'h1);
        supply_low <= 1'h0;
        repeat (3) @(posedge clk);
        check(32'({phase_low_gate, phase_high_gate}), 32'h38);
        repeat (RF + DT + 4) @(posedge clk);
        check(32'(phase_high_gate[1]), 32'h1);
    endtask : t_refresh
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'h1;
        t_reset();
        t_separate();
        t_joined();
        t_refresh();
        conclude();
    end
endmodule : testbench

`default_nettype wire
